// ### hw/lpd_pkg.sv
/*
  Constants and types for the panel drive timing block.
  Assumes one system clock of 10 MHz and a second link clock that paces the panel pins.
*/
// What this block does
// - Drive column and row drivers directly; column chips selected by an enable chain.
// - Pixel data leaves on a 4-bit parallel column bus.
// - Column data is stable for two link cycles before each falling edge of the column shift clock.
// - Column shift clock is stopped from line latch until the next line starts.
// - Pulse the enable-chain clock; its falling edges step the enable cascade.
// - One line latch pulse per line; its falling edge latches column outputs.
// - Generate backplane alternation with a programmable period.
// - Drive row shift clock; row drivers sample frame start on its falling edge.
// - Assert frame start pulse during the last line of every frame.
// - Row-drive-active high while running; low one or two frames after power save.
// - Operating clock comes from external clock input or crystal oscillator.
package lpd_pkg;
  localparam int unsigned DATA_W         = 4;     // column bus width
  localparam int unsigned CHAIN_GROUP    = 16;    // chain pulses per column chip
  localparam int unsigned DEF_GROUPS     = 80;    // 4-bit groups per line
  localparam int unsigned DEF_LINES      = 240;   // lines per frame
  localparam int unsigned DEF_ALT_LINES  = 13;    // lines per backplane half period
  localparam int unsigned LATCH_TICKS    = 2;     // link cycles of line latch high
  localparam int unsigned GAP_TICKS      = 2;     // idle link cycles after latch
  localparam int unsigned CNT_W          = 12;    // width of the line and group counters
  localparam int unsigned BUF_DEPTH      = 2;     // entries in the data buffer

  typedef enum logic [2:0] {
    LPD_IDLE,
    LPD_SHIFT_HI,
    LPD_SHIFT_LO,
    LPD_LATCH,
    LPD_GAP
  } lpd_state_type;
endpackage : lpd_pkg

// ### hw/lpd_drive.sv
/*
  Panel drive timing: takes pixel nibbles on the system clock, buffers them,
  carries them to the link clock domain and plays out column, row and
  backplane signals for a passive matrix panel.
  Assumes the link clock runs freely once out of reset and that the clock
  source selection (crystal or external) is done by the pad ring in front of clock.
*/
`timescale 1ns/10ps
module lpd_drive
  import lpd_pkg::*;
#(
  parameter int unsigned GROUPS    = lpd_pkg::DEF_GROUPS,
  parameter int unsigned LINES     = lpd_pkg::DEF_LINES,
  parameter int unsigned ALT_LINES = lpd_pkg::DEF_ALT_LINES
) (
  // system side
  input  wire logic                       clock,                    // crystal or external, picked ahead
  input  wire logic                       arst_n,
  input  wire logic                       run,
  input  wire logic                       power_save,
  input  wire logic [lpd_pkg::DATA_W-1:0] pixel_data,
  input  wire logic                       pixel_valid,
  output logic                            pixel_ready,
  output logic                            drive_active,
  // link side
  input  wire logic                       link_clock,
  output logic [lpd_pkg::DATA_W-1:0]      panel_column_data,
  output logic                            column_shift_clock,
  output logic                            column_enable_chain_clock,
  output logic                            line_latch_pulse,
  output logic                            backplane_alternation,
  output logic                            row_shift_clock,
  output logic                            frame_start_pulse,
  output logic                            row_drive_active
);
  import lpd_pkg::*;

  // overview of the two clock domains
  //
  // system domain (clock):
  //   the pixel source pushes nibbles into a two-entry buffer with a
  //   registered ready, so a stall at the panel never drops a word
  //   the buffer head is offered to the link through a toggle handshake;
  //   the data word is held still while the toggle is outstanding, so only
  //   the one-bit request and acknowledge need synchronisers
  //   row drive state comes back through three flip-flops as drive_active
  //
  // link domain (link_clock):
  //   a one-word holding register takes the offered nibble
  //   the sequencer plays each line as GROUPS shift pulses, a latch pulse
  //   and a short gap; the shift clock stays low from latch to next line
  //   run and power_save cross in as levels through two flip-flops
  //
  // word flow per shift pulse:
  //   the held word is taken at the edge that enters the shift-high state,
  //   and put on the column bus at that same edge; the acknowledge toggles
  //   there too, so the next word can already be on its way while the
  //   present one is being clocked into the column drivers
  //   taking the word here and not at the falling shift edge means that a
  //   set holding flag inside the shift-low state always names a fresh word,
  //   so a nibble is never shifted twice
  //
  // limitations:
  //   the column bus changes on the link edge that drops the shift clock,
  //   so the hold time seen by the drivers is one clock-to-output delay
  //   a starved line pauses with the shift clock low and resumes where it
  //   stopped; the latch is never issued for a partial line
  //   power save waits for frame ends so the row scan never stops mid-frame
  //
  // trade-offs:
  //   one word in flight across the domains keeps the crossing simple;
  //   throughput is bounded by the handshake round trip, which is ample
  //   for a panel whose shift clock runs well below the link clock

  // two-entry buffer on the system clock
  logic [DATA_W-1:0] buf_mem [BUF_DEPTH];
  logic              wr_ptr;
  logic              rd_ptr;
  logic [1:0]        buf_count;
  logic              buf_push;
  logic              buf_pop;
  logic              buf_valid;

  // word handshake between domains
  logic [DATA_W-1:0] xfer_data;
  logic              xfer_req;
  logic              ack_meta;
  logic              ack_sync;
  logic              req_meta;
  logic              req_sync;
  logic              req_seen;
  logic              xfer_ack;

  // link side state
  lpd_state_type     state;
  logic [CNT_W-1:0]  group_cnt;
  logic [CNT_W-1:0]  line_cnt;
  logic [CNT_W-1:0]  alt_cnt;
  logic [1:0]        tick_cnt;
  logic              link_have;
  logic [DATA_W-1:0] link_word;
  logic              run_meta;
  logic              run_sync;
  logic              save_meta;
  logic              save_sync;
  logic              frame_end;
  logic [1:0]        save_frames;
  logic              act_meta;
  logic              act_sync;
  logic              take_word;

  // a held word is taken as its shift pulse is launched, so that in the
  // shift-low state link_have always means the next word is ready
  assign take_word = link_have &&
                     (((state == LPD_IDLE) && run_sync && row_drive_active) ||
                      ((state == LPD_SHIFT_LO) && (group_cnt != CNT_W'(GROUPS - 1))));

  assign buf_valid = (buf_count != 2'h0);
  assign buf_push  = pixel_valid && pixel_ready;
  assign buf_pop   = buf_valid && (xfer_req == ack_sync);

  // buffer fill level and ready; ready is registered so it stalls the source honestly
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      buf_count   <= 2'h0;
      pixel_ready <= 1'b0;
    end else begin
      buf_count   <= buf_count + 2'(buf_push) - 2'(buf_pop);
      pixel_ready <= (2'(buf_count + 2'(buf_push) - 2'(buf_pop)) < 2'(BUF_DEPTH));
    end
  end

  // buffer storage and pointers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
    end else begin
      if (buf_push) begin
        buf_mem[wr_ptr] <= pixel_data;
        wr_ptr          <= ~wr_ptr;
      end
      if (buf_pop) begin
        rd_ptr <= ~rd_ptr;
      end
    end
  end

  // toggle handshake: data is held stable while the request is outstanding
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      xfer_req  <= 1'b0;
      xfer_data <= '0;
    end else if (buf_pop) begin
      xfer_data <= buf_mem[rd_ptr];
      xfer_req  <= ~xfer_req;
    end
  end

  // acknowledge and drive status come back into the system clock
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ack_meta     <= 1'b0;
      ack_sync     <= 1'b0;
      act_meta     <= 1'b0;
      act_sync     <= 1'b0;
      drive_active <= 1'b0;
    end else begin
      ack_meta     <= xfer_ack;
      ack_sync     <= ack_meta;
      act_meta     <= row_drive_active;
      act_sync     <= act_meta;
      drive_active <= act_sync;
    end
  end

  // control levels cross into the link domain
  always_ff @(posedge link_clock or negedge arst_n) begin
    if (!arst_n) begin
      req_meta  <= 1'b0;
      req_sync  <= 1'b0;
      run_meta  <= 1'b0;
      run_sync  <= 1'b0;
      save_meta <= 1'b0;
      save_sync <= 1'b0;
    end else begin
      req_meta  <= xfer_req;
      req_sync  <= req_meta;
      run_meta  <= run;
      run_sync  <= run_meta;
      save_meta <= power_save;
      save_sync <= save_meta;
    end
  end

  // one-word holding register at the link; ack only once the word is taken
  always_ff @(posedge link_clock or negedge arst_n) begin
    if (!arst_n) begin
      req_seen  <= 1'b0;
      xfer_ack  <= 1'b0;
      link_have <= 1'b0;
      link_word <= '0;
    end else begin
      if (take_word) begin
        // the word moves to the column bus at this edge, so it may be released
        link_have <= 1'b0;
        xfer_ack  <= req_seen;
      end else if (!link_have && (req_sync != req_seen)) begin
        link_word <= xfer_data;
        link_have <= 1'b1;
        req_seen  <= req_sync;
      end
    end
  end

  assign frame_end = (state == LPD_GAP) && (tick_cnt == 2'h0) && (line_cnt == CNT_W'(LINES - 1));

  // line sequencer: shift pulses per group, then latch, then gap
  always_ff @(posedge link_clock or negedge arst_n) begin
    if (!arst_n) begin
      state     <= LPD_IDLE;
      group_cnt <= '0;
      line_cnt  <= '0;
      tick_cnt  <= 2'h0;
    end else begin
      case (state)
        LPD_IDLE: begin
          if (run_sync && row_drive_active && link_have) begin
            state <= LPD_SHIFT_HI;
          end
        end
        LPD_SHIFT_HI: begin
          state <= LPD_SHIFT_LO;
        end
        LPD_SHIFT_LO: begin
          if (group_cnt == CNT_W'(GROUPS - 1)) begin
            group_cnt <= '0;
            tick_cnt  <= 2'(LATCH_TICKS - 1);
            state     <= LPD_LATCH;
          end else if (link_have) begin
            group_cnt <= group_cnt + 1'b1;
            state     <= LPD_SHIFT_HI;
          end else begin
            group_cnt <= group_cnt + 1'b1;
            state     <= LPD_IDLE;                                      // starved: wait
          end
        end
        LPD_LATCH: begin
          if (tick_cnt == 2'h0) begin
            tick_cnt <= 2'(GAP_TICKS - 1);
            state    <= LPD_GAP;
          end else begin
            tick_cnt <= tick_cnt - 1'b1;
          end
        end
        LPD_GAP: begin
          if (tick_cnt != 2'h0) begin
            tick_cnt <= tick_cnt - 1'b1;
          end else begin
            line_cnt <= (line_cnt == CNT_W'(LINES - 1)) ? '0 : line_cnt + 1'b1;
            state    <= LPD_IDLE;
          end
        end
        default: state <= LPD_IDLE;
      endcase
    end
  end

  // column outputs: data set a cycle before the shift clock rises, captured on its fall
  always_ff @(posedge link_clock or negedge arst_n) begin
    if (!arst_n) begin
      panel_column_data         <= '0;
      column_shift_clock        <= 1'b0;
      column_enable_chain_clock <= 1'b0;
    end else begin
      // new data only as a pulse is launched, a cycle ahead of its rising edge
      if (take_word) begin
        panel_column_data <= link_word;
      end
      column_shift_clock        <= (state == LPD_SHIFT_HI);
      column_enable_chain_clock <= (state == LPD_SHIFT_HI);
    end
  end

  // line latch, row clock and frame token
  always_ff @(posedge link_clock or negedge arst_n) begin
    if (!arst_n) begin
      line_latch_pulse  <= 1'b0;
      row_shift_clock   <= 1'b0;
      frame_start_pulse <= 1'b0;
    end else begin
      line_latch_pulse  <= (state == LPD_LATCH);
      row_shift_clock   <= (state == LPD_LATCH);
      frame_start_pulse <= (line_cnt == CNT_W'(LINES - 1));
    end
  end

  // backplane alternation toggles every ALT_LINES lines
  always_ff @(posedge link_clock or negedge arst_n) begin
    if (!arst_n) begin
      alt_cnt               <= '0;
      backplane_alternation <= 1'b0;
    end else if (state == LPD_GAP && tick_cnt == 2'h0) begin
      if (alt_cnt == CNT_W'(ALT_LINES - 1)) begin
        alt_cnt               <= '0;
        backplane_alternation <= ~backplane_alternation;
      end else begin
        alt_cnt <= alt_cnt + 1'b1;
      end
    end
  end

  // power save: wait for frame ends so the panel never stops mid-frame
  always_ff @(posedge link_clock or negedge arst_n) begin
    if (!arst_n) begin
      save_frames      <= 2'h0;
      row_drive_active <= 1'b0;
    end else begin
      if (!save_sync) begin
        save_frames      <= 2'h0;
        row_drive_active <= run_sync;
      end else if (frame_end && row_drive_active) begin
        if (save_frames == 2'h1) begin
          row_drive_active <= 1'b0;
        end
        save_frames <= save_frames + 1'b1;
      end
    end
  end
endmodule : lpd_drive

// ### test/lpd_chk.sv
/* pin timing checker for lpd_drive
   bound onto the drive block; sees only its link side ports and the reset arst_n */
`timescale 1ns/10ps
module lpd_chk (
  // link clock and reset
  input wire logic                       link_clock,
  input wire logic                       arst_n,
  // panel pins
  input wire logic [lpd_pkg::DATA_W-1:0] panel_column_data,
  input wire logic                       column_shift_clock,
  input wire logic                       column_enable_chain_clock,
  input wire logic                       line_latch_pulse,
  input wire logic                       row_shift_clock,
  input wire logic                       row_drive_active
);
  import lpd_pkg::*;
  // every check lives on the link clock
  default clocking @(posedge link_clock); endclocking
  default disable iff (!arst_n);
  property p_lat; $rose(line_latch_pulse) |=> line_latch_pulse ##1 !line_latch_pulse; endproperty
  a_lat: assert property (p_lat) else $error("latch width");
  property p_shw; $rose(column_shift_clock) |=> !column_shift_clock; endproperty
  a_shw: assert property (p_shw) else $error("shift width");
  property p_dat; $rose(column_shift_clock) |-> $stable(panel_column_data); endproperty
  a_dat: assert property (p_dat) else $error("data moved");
  property p_gap; $fell(line_latch_pulse) |-> !column_shift_clock [*2]; endproperty
  a_gap: assert property (p_gap) else $error("shift in gap");
  property p_stp; line_latch_pulse |-> !column_shift_clock; endproperty
  a_stp: assert property (p_stp) else $error("shift in latch");
  property p_chn; column_enable_chain_clock == column_shift_clock; endproperty
  a_chn: assert property (p_chn) else $error("chain clock");
  property p_row; row_shift_clock == line_latch_pulse; endproperty
  a_row: assert property (p_row) else $error("row clock");
  // reset itself is the cause here, so this one is never disabled
  property p_rst; disable iff (1'b0) !arst_n && $past(!arst_n) |-> !row_drive_active; endproperty
  a_rst: assert property (p_rst) else $error("active in reset");
  c_lat: cover property ($fell(line_latch_pulse));
  c_off: cover property ($fell(row_drive_active));
  c_shf: cover property ($rose(column_shift_clock));
endmodule : lpd_chk
bind lpd_drive lpd_chk u_chk (.*);

// ### test/lpd_panel.sv
/* behavioural column and row driver chips of the panel
   assumes the panel pins of lpd_drive and its link clock */
`timescale 1ns/10ps
module lpd_panel
  import lpd_pkg::*;
#(
  parameter int unsigned GROUPS = 4,
  parameter int unsigned LINES  = 4
) (
  // panel pins
  input wire logic                       link_clock,
  input wire logic [lpd_pkg::DATA_W-1:0] panel_column_data,
  input wire logic                       column_shift_clock,
  input wire logic                       column_enable_chain_clock,
  input wire logic                       line_latch_pulse,
  input wire logic                       row_shift_clock,
  input wire logic                       frame_start_pulse,
  input wire logic                       row_drive_active,
  // what the chips hold
  output logic [GROUPS*4-1:0]            line_out,
  output logic [31:0]                    shifts_seen,
  output logic [LINES-1:0]               rows,
  output logic [LINES-1:0]               row_out
);
  logic [GROUPS*4-1:0] sr;
  logic [DATA_W-1:0]   d_q;
  logic                sh_q, ch_q, lp_q, ys_q, fs_q;
  int                  shifts = 0, chain = 0;
  // pins held from the last half cycle stand for the value before a falling edge (zero hold)
  always @(negedge link_clock) begin
    if (sh_q && !column_shift_clock) begin
      sr = {sr[GROUPS*4-DATA_W-1:0], d_q};
      shifts++;
    end
    if (ch_q && !column_enable_chain_clock) chain++; // chip chain/CHAIN_GROUP is enabled
    if (lp_q && !line_latch_pulse) begin
      line_out = sr;
      shifts_seen = shifts;
      shifts = 0;
      chain = 0;
    end
    // latch pin is not our row clock, so only the row clock shifts
    if (ys_q && !row_shift_clock) rows = {rows[LINES-2:0], fs_q};
    {d_q, sh_q, ch_q, lp_q, ys_q, fs_q} = {panel_column_data, column_shift_clock,
      column_enable_chain_clock, line_latch_pulse, row_shift_clock, frame_start_pulse};
  end
  // deselect level shown as zero
  assign row_out = row_drive_active ? rows : '0;
endmodule : lpd_panel

// ### test/lpd_drive_test.sv
/* self-checking bench for lpd_drive with a queue model and a panel model
   assumes nothing around it; makes both clocks and the reset */
`timescale 1ns/10ps
module lpd_drive_test;
  import lpd_pkg::*;
  localparam int unsigned G = 4;
  localparam int unsigned L = 4;
  localparam int unsigned A = 2;
  logic clock = 0, link_clock = 0, arst_n = 0, run = 0, power_save = 0, pixel_valid = 0, feed = 1;
  logic pixel_ready, drive_active, column_shift_clock, column_enable_chain_clock, line_latch_pulse;
  logic backplane_alternation, row_shift_clock, frame_start_pulse, row_drive_active, fs, bp;
  logic [DATA_W-1:0] pixel_data = '0, panel_column_data, exp_q[$];
  logic [G*4-1:0]    line_out, e;
  logic [31:0]       shifts_seen, rnd = 32'h059b0db9;
  logic [L-1:0]      rows, row_out;
  logic [3:0]        bph = '0;
  int                bad_count = 0, compares = 0, nlines = 0, k, n;
  lpd_drive #(.GROUPS(G), .LINES(L), .ALT_LINES(A)) u_dut (.*);
  lpd_panel #(.GROUPS(G), .LINES(L)) u_pan (.*);
  // clocks of unrelated phase
  always #50 clock = ~clock;
  always #7.5 link_clock = ~link_clock;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    compares++;
    if (seen !== want) begin
      bad_count++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic end_sim;
    if (bad_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic bound(input logic ok);
    check(ok, 1'b1);
    if (!ok) end_sim();
  endtask : bound
  // random nibbles; a refused word is held until taken
  always @(posedge clock) begin
    if (pixel_valid && pixel_ready) exp_q.push_back(pixel_data);
    if (!pixel_valid || pixel_ready) begin
      rnd = xs(rnd);
      #1;
      pixel_valid = feed & rnd[0] & arst_n;
      pixel_data = rnd[7:4];
    end
  end
  // mid-line view of frame start and backplane
  always @(negedge link_clock) if (column_shift_clock) {fs, bp} = {frame_start_pulse, backplane_alternation};
  // each latched line against the reference queue
  always @(negedge line_latch_pulse) if (arst_n) begin
    @(negedge link_clock);
    #1;
    for (int i = 0; i < G; i++) e = {e[G*4-DATA_W-1:0], exp_q.size() > 0 ? exp_q.pop_front() : 4'hx};
    check(line_out, e);
    check(shifts_seen, G);
    check(fs, nlines % L == L - 1);
    check(rows[0], fs);
    bph = {bph[2:0], bp};
    if (nlines >= A) check(bph[A] ^ bph[0], 1'b1);
    nlines++;
  end
  // fill with the panel idle, run, starve, then power save
  initial begin
    repeat (8) @(posedge clock);
    check(row_drive_active, 1'b0);
    repeat (8) @(posedge clock);
    #1 arst_n = 1;
    repeat (3) @(posedge clock);
    for (k = 0; k < 100 && pixel_ready; k++) @(posedge clock);
    bound(!pixel_ready && exp_q.size() >= BUF_DEPTH);
    #1 run = 1;
    for (k = 0; k < 9000 && nlines < 6; k++) @(posedge clock);
    bound(nlines >= 6);
    check(row_drive_active & drive_active, 1'b1);
    #1 feed = 0;
    repeat (200) @(posedge clock);
    #1 feed = 1;
    for (k = 0; k < 9000 && nlines < 12; k++) @(posedge clock);
    bound(nlines >= 12);
    #1 power_save = 1;
    n = nlines;
    for (k = 0; k < 9000 && row_drive_active; k++) @(posedge clock);
    bound(!row_drive_active);
    check(nlines - n >= L - 1 && nlines - n <= 2 * L + 1, 1'b1);
    repeat (6) @(posedge clock);
    check({drive_active, row_out}, '0);
    end_sim();
  end
endmodule : lpd_drive_test
